// ### acc_params.svh
// constants for the calibration control register bank: offsets, fields, resets
// assumes inclusion by bare name from the package and the register module
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// ==========================================================================
// register indices (byte address on the bus is four times the index)
`define ACC_IDX_AVG 8'h68
`define ACC_IDX_STATUS 8'h6a
`define ACC_IDX_PIN 8'h6b
`define ACC_IDX_SOFT 8'h6c
`define ACC_IDX_CFG 8'h70
`define ACC_IDX_INT_STATUS 8'h71
`define ACC_IDX_INT_MASK 8'h72

// ==========================================================================
// reset values
`define ACC_RST_AVG 8'h61
`define ACC_RST_STATUS 8'h00
`define ACC_RST_PIN 8'h00
`define ACC_RST_SOFT 8'h01
`define ACC_RST_CFG 8'h00
`define ACC_RST_INT_MASK 8'h00

// ==========================================================================
// writable-bit masks; reserved positions are never stored and read as zero
`define ACC_WMASK_AVG 8'h77
`define ACC_WMASK_PIN 8'h07
`define ACC_WMASK_SOFT 8'h01
`define ACC_WMASK_CFG 8'h07
`define ACC_WMASK_INT 8'h1f

// ==========================================================================
// field positions
`define ACC_AVG_OFS_LSB 4
`define ACC_AVG_LIN_LSB 0
`define ACC_ST_CODE_LSB 2
`define ACC_ST_STOPPED 1
`define ACC_ST_FOREGROUND_COMPLETE_FLAG 0
`define ACC_PIN_SEL_LSB 1
`define ACC_PIN_TRIG_SRC 0
`define ACC_SOFT_TRIG 0
`define ACC_CFG_BG_EN 0
`define ACC_CFG_LP_EN 1
`define ACC_CFG_TRIG_SLEEP 2

// interrupt status bits
`define ACC_INT_FOREGROUND_COMPLETE_FLAG 0
`define ACC_INT_STOPPED 1
`define ACC_INT_RESUMED 2
`define ACC_INT_ALARM 3
`define ACC_INT_TRIG_EDGE 4

`endif

// ### acc_pkg.sv
// types shared by the calibration control register bank
// assumes acc_params.svh sits in the same folder
`include "acc_params.svh"

package acc_pkg;

  // status pin source selection
  typedef enum logic [1:0] {
    ACC_SEL_FOREGROUND_COMPLETE_FLAG = 2'b00,
    ACC_SEL_STOPPED = 2'b01,
    ACC_SEL_ALARM = 2'b10,
    ACC_SEL_LOW = 2'b11
  } acc_status_sel_t;

  // one 8-bit register image
  typedef logic [7:0] acc_reg_t;

endpackage

// ### acc_sync3.sv
// three-stage synchroniser with agreement filter for one asynchronous pin
// assumes the pin may change at any time relative to clk
`timescale 1ns/1ps
`default_nettype none

module acc_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);

  logic s1;
  logic s2;
  logic s3;
  logic next_sync_out;

  // ==========================================================================
  // filter: the output follows only when stages two and three agree
  always_comb begin
    next_sync_out = sync_out;
    if (s2 == s3) begin
      next_sync_out = s3;
    end
  end

  // stage one is read only by stage two, to keep metastability contained
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      sync_out <= next_sync_out;
    end
  end

endmodule
`default_nettype wire

// ### acc_cal_regs.sv
// calibration control and status register bank with apb slave
// assumes the calibration engine runs on clk and gives one-cycle event pulses;
// the external trigger pin is asynchronous and is synchronised here
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "acc_params.svh"

// Notes on behaviour
// - offset averaging field, bits 6:4, writable, resets to 6.
// - linearity averaging field, bits 2:0, writable, resets to 1.
// - status register read-only; status code in bits 4:2 from the engine.
// - stopped flag, bit 1, rises when background calibration halts.
// - stopped flag clears when calibration resumes.
// - without background calibration, stopped sets on foreground finish or skip.
// - foreground done flag, bit 0, set on completion or skip.
// - select field bits 2:1 picks done, stopped, alarm or low for status pin.
// - source bit 0 takes the software trigger, pin ignored.
// - source bit 1 takes the trigger pin, software bit ignored.
// - software trigger bit 0 of its register, resets to 1.
// - triggered sleep, with low power and background calibration also enabled, wakes converter while trigger low, sleeps while high.
module acc_cal_regs #(
  parameter int ADDR_W = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // calibration engine side, same clock
  input wire logic cal_restart,
  input wire logic fg_finished,
  input wire logic bg_halted,
  input wire logic bg_resumed,
  input wire logic alarm_in,
  input wire logic [2:0] cal_stat_code,
  // pins
  input wire logic calibration_trigger_pin,
  output logic calibration_status_pin,
  // outputs to the calibration and power logic
  output logic calibration_trigger,
  output logic converter_wake,
  output logic [2:0] offset_averaging_level,
  output logic [2:0] linearity_averaging_level,
  output logic background_calibration_enable,
  output logic irq
);

  // ==========================================================================
  // register state
  acc_pkg::acc_reg_t avg_reg;
  acc_pkg::acc_reg_t pin_reg;
  acc_pkg::acc_reg_t soft_reg;
  acc_pkg::acc_reg_t cfg_reg;
  acc_pkg::acc_reg_t int_status;
  acc_pkg::acc_reg_t int_mask;
  acc_pkg::acc_reg_t next_avg_reg;
  acc_pkg::acc_reg_t next_pin_reg;
  acc_pkg::acc_reg_t next_soft_reg;
  acc_pkg::acc_reg_t next_cfg_reg;
  acc_pkg::acc_reg_t next_int_status;
  acc_pkg::acc_reg_t next_int_mask;

  // calibration flags
  logic foreground_complete_flag_flag;
  logic stopped_flag;
  logic alarm_flag;
  logic [2:0] stat_code;
  logic next_foreground_complete_flag_flag;
  logic next_stopped_flag;
  logic next_alarm_flag;
  logic [2:0] next_stat_code;

  // bus answer
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // pin side
  logic trig_pin_sync;
  logic next_calibration_trigger;
  logic next_converter_wake;
  logic next_status_pin;
  logic next_irq;

  // decode helpers
  logic [7:0] idx;
  logic aligned;
  logic setup_phase;
  logic access_done;
  logic wr_en;
  logic hit;
  logic [7:0] wbyte;
  acc_pkg::acc_reg_t status_image;
  acc_pkg::acc_status_sel_t status_sel;
  logic [7:0] int_events;

  // ==========================================================================
  // external trigger pin synchroniser; idle level high means no trigger
  acc_sync3 #(
    .RST_VAL(1'b1)
  ) u_trig_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(calibration_trigger_pin),
    .sync_out(trig_pin_sync)
  );

  // ==========================================================================
  // address decode
  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign setup_phase = psel && !penable && !pready;
  // a write lands only at the edge where the access phase sees pready
  assign access_done = psel && penable && pready;
  assign wr_en = access_done && pwrite && !pslverr && pstrb[0];
  assign wbyte = pwdata[7:0];
  assign status_sel = acc_pkg::acc_status_sel_t'(pin_reg[`ACC_PIN_SEL_LSB +: 2]);

  // mapped addresses
  always_comb begin
    hit = 1'b0;
    if (aligned) begin
      case (idx)
        `ACC_IDX_AVG: hit = 1'b1;
        `ACC_IDX_STATUS: hit = 1'b1;
        `ACC_IDX_PIN: hit = 1'b1;
        `ACC_IDX_SOFT: hit = 1'b1;
        `ACC_IDX_CFG: hit = 1'b1;
        `ACC_IDX_INT_STATUS: hit = 1'b1;
        `ACC_IDX_INT_MASK: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end

  // status image built only from engine state
  always_comb begin
    status_image = 8'h00;
    status_image[`ACC_ST_CODE_LSB +: 3] = stat_code;
    status_image[`ACC_ST_STOPPED] = stopped_flag;
    status_image[`ACC_ST_FOREGROUND_COMPLETE_FLAG] = foreground_complete_flag_flag;
  end

  // ==========================================================================
  // apb answer: data and pready are registered in the setup cycle, so every
  // access has exactly one access cycle and no wait states
  always_comb begin
    next_pready = setup_phase;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (setup_phase) begin
      next_pslverr = !hit;
      next_prdata = 32'h0000_0000;
      if (!pwrite && hit) begin
        case (idx)
          `ACC_IDX_AVG: next_prdata[7:0] = avg_reg;
          `ACC_IDX_STATUS: next_prdata[7:0] = status_image;
          `ACC_IDX_PIN: next_prdata[7:0] = pin_reg;
          `ACC_IDX_SOFT: next_prdata[7:0] = soft_reg;
          `ACC_IDX_CFG: next_prdata[7:0] = cfg_reg;
          `ACC_IDX_INT_STATUS: next_prdata[7:0] = int_status;
          `ACC_IDX_INT_MASK: next_prdata[7:0] = int_mask;
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================================
  // software-written registers; status register ignores writes entirely
  always_comb begin
    next_avg_reg = avg_reg;
    next_pin_reg = pin_reg;
    next_soft_reg = soft_reg;
    next_cfg_reg = cfg_reg;
    next_int_mask = int_mask;
    if (wr_en) begin
      // reserved positions are not stored, so stray ones do no harm
      case (idx)
        `ACC_IDX_AVG: next_avg_reg = wbyte & `ACC_WMASK_AVG;
        `ACC_IDX_PIN: next_pin_reg = wbyte & `ACC_WMASK_PIN;
        `ACC_IDX_SOFT: next_soft_reg = wbyte & `ACC_WMASK_SOFT;
        `ACC_IDX_CFG: next_cfg_reg = wbyte & `ACC_WMASK_CFG;
        `ACC_IDX_INT_MASK: next_int_mask = wbyte & `ACC_WMASK_INT;
        default: next_avg_reg = avg_reg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avg_reg <= `ACC_RST_AVG;
      pin_reg <= `ACC_RST_PIN;
      soft_reg <= `ACC_RST_SOFT;
      cfg_reg <= `ACC_RST_CFG;
      int_mask <= `ACC_RST_INT_MASK;
    end else begin
      avg_reg <= next_avg_reg;
      pin_reg <= next_pin_reg;
      soft_reg <= next_soft_reg;
      cfg_reg <= next_cfg_reg;
      int_mask <= next_int_mask;
    end
  end

  // ==========================================================================
  // calibration flags; a set event in the restart cycle still wins
  always_comb begin
    next_foreground_complete_flag_flag = foreground_complete_flag_flag;
    next_stopped_flag = stopped_flag;
    next_alarm_flag = alarm_in;
    next_stat_code = cal_stat_code;
    if (cal_restart) begin
      next_foreground_complete_flag_flag = 1'b0;
      next_stopped_flag = 1'b0;
    end
    if (bg_resumed) begin
      next_stopped_flag = 1'b0;
    end
    if (fg_finished) begin
      next_foreground_complete_flag_flag = 1'b1;
    end
    if (bg_halted && cfg_reg[`ACC_CFG_BG_EN]) begin
      next_stopped_flag = 1'b1;
    end
    if (fg_finished && !cfg_reg[`ACC_CFG_BG_EN]) begin
      next_stopped_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      foreground_complete_flag_flag <= 1'b0;
      stopped_flag <= 1'b0;
      alarm_flag <= 1'b0;
      stat_code <= 3'h0;
    end else begin
      foreground_complete_flag_flag <= next_foreground_complete_flag_flag;
      stopped_flag <= next_stopped_flag;
      alarm_flag <= next_alarm_flag;
      stat_code <= next_stat_code;
    end
  end

  // ==========================================================================
  // trigger selection, status pin and sleep control
  always_comb begin
    if (pin_reg[`ACC_PIN_TRIG_SRC]) begin
      next_calibration_trigger = trig_pin_sync;
    end else begin
      next_calibration_trigger = soft_reg[`ACC_SOFT_TRIG];
    end
    case (status_sel)
      acc_pkg::ACC_SEL_FOREGROUND_COMPLETE_FLAG: next_status_pin = next_foreground_complete_flag_flag;
      acc_pkg::ACC_SEL_STOPPED: next_status_pin = next_stopped_flag;
      acc_pkg::ACC_SEL_ALARM: next_status_pin = next_alarm_flag;
      acc_pkg::ACC_SEL_LOW: next_status_pin = 1'b0;
      default: next_status_pin = 1'b0;
    endcase
    // wake while trigger low; next values keep wake in step with trigger
    next_converter_wake = next_cfg_reg[`ACC_CFG_LP_EN] && next_cfg_reg[`ACC_CFG_BG_EN] &&
      next_cfg_reg[`ACC_CFG_TRIG_SLEEP] && !next_calibration_trigger;
  end

  // trigger resets high so a quiet system sees no trigger request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      calibration_trigger <= 1'b1;
      calibration_status_pin <= 1'b0;
      converter_wake <= 1'b0;
    end else begin
      calibration_trigger <= next_calibration_trigger;
      calibration_status_pin <= next_status_pin;
      converter_wake <= next_converter_wake;
    end
  end

  // ==========================================================================
  // interrupt events are edges of the visible flags and of the trigger
  always_comb begin
    int_events = 8'h00;
    int_events[`ACC_INT_FOREGROUND_COMPLETE_FLAG] = next_foreground_complete_flag_flag && !foreground_complete_flag_flag;
    int_events[`ACC_INT_STOPPED] = next_stopped_flag && !stopped_flag;
    int_events[`ACC_INT_RESUMED] = !next_stopped_flag && stopped_flag;
    int_events[`ACC_INT_ALARM] = next_alarm_flag && !alarm_flag;
    int_events[`ACC_INT_TRIG_EDGE] = next_calibration_trigger != calibration_trigger;
  end

  // sticky status, write one to clear; a new event beats a clear in the same cycle
  always_comb begin
    next_int_status = int_status;
    if (wr_en && idx == `ACC_IDX_INT_STATUS) begin
      next_int_status = int_status & ~wbyte;
    end
    next_int_status = (next_int_status | int_events) & `ACC_WMASK_INT;
    next_irq = |(next_int_status & int_mask);
    // mask writes take effect on the same edge as the stored mask
    if (wr_en && idx == `ACC_IDX_INT_MASK) begin
      next_irq = |(next_int_status & wbyte & `ACC_WMASK_INT);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_status <= 8'h00;
      irq <= 1'b0;
    end else begin
      int_status <= next_int_status;
      irq <= next_irq;
    end
  end

  // ==========================================================================
  // field outputs straight from the register flops
  assign offset_averaging_level = avg_reg[`ACC_AVG_OFS_LSB +: 3];
  assign linearity_averaging_level = avg_reg[`ACC_AVG_LIN_LSB +: 3];
  assign background_calibration_enable = cfg_reg[`ACC_CFG_BG_EN];

endmodule
`default_nettype wire

// ### acc_cal_regs_monitor.sv
// checker for the calibration register bank, bound to its top module
// assumes one clock domain and the port names of acc_cal_regs
`timescale 1ns/1ps
`default_nettype none
module acc_cal_regs_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cal_restart,
  input wire logic fg_finished,
  input wire logic bg_halted,
  input wire logic bg_resumed,
  input wire logic alarm_in,
  input wire logic calibration_trigger_pin,
  input wire logic calibration_status_pin,
  input wire logic calibration_trigger,
  input wire logic converter_wake,
  input wire logic [2:0] offset_averaging_level,
  input wire logic [2:0] linearity_averaging_level,
  input wire logic background_calibration_enable
);
  // ==========================================
  // helpers
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic wr_acc;
  logic ev_any;
  logic pin_d;
  logic [3:0] quiet;
  assign wr_acc = psel && penable && pready && pwrite;
  assign ev_any = cal_restart || fg_finished || bg_halted || bg_resumed;
  // cycles since the pin moved; the synchroniser needs about five
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_d <= 1'b1;
      quiet <= 4'h0;
    end else begin
      pin_d <= calibration_trigger_pin;
      if (calibration_trigger_pin != pin_d) quiet <= 4'h0;
      else if (quiet != 4'hf) quiet <= quiet + 4'h1;
    end
  end
  // ==========================================
  // properties
  property p_ofs; !$stable(offset_averaging_level) |-> $past(wr_acc); endproperty
  a_ofs: assert property (p_ofs)
    else $error("offset level moved without a write");
  property p_lin; !$stable(linearity_averaging_level) |-> $past(wr_acc); endproperty
  a_lin: assert property (p_lin)
    else $error("linearity level moved without a write");
  property p_bgen; !$stable(background_calibration_enable) |-> $past(wr_acc); endproperty
  a_bgen: assert property (p_bgen)
    else $error("background enable moved without a write");
  property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy)
    else $error("ready not a single pulse after setup");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err)
    else $error("error without ready");
  property p_wake; converter_wake |-> !calibration_trigger && background_calibration_enable;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake while trigger high or disabled");
  property p_trig; $changed(calibration_trigger) |-> $past(wr_acc, 2) || quiet < 4'h8; endproperty
  a_trig: assert property (p_trig)
    else $error("trigger moved without a cause");
  property p_stat;
    $changed(calibration_status_pin) |-> $past(wr_acc, 2) || $past(ev_any)
      || $past(alarm_in) != $past(alarm_in, 2) || $past(alarm_in, 2) != $past(alarm_in, 3);
  endproperty
  a_stat: assert property (p_stat)
    else $error("status pin moved without a cause");
  c_wake: cover property (converter_wake);
  c_err: cover property (pslverr);
  c_stat: cover property ($rose(calibration_status_pin));
endmodule
bind acc_cal_regs acc_cal_regs_monitor mon (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .cal_restart(cal_restart), .fg_finished(fg_finished), .bg_halted(bg_halted),
  .bg_resumed(bg_resumed), .alarm_in(alarm_in),
  .calibration_trigger_pin(calibration_trigger_pin),
  .calibration_status_pin(calibration_status_pin),
  .calibration_trigger(calibration_trigger), .converter_wake(converter_wake),
  .offset_averaging_level(offset_averaging_level),
  .linearity_averaging_level(linearity_averaging_level),
  .background_calibration_enable(background_calibration_enable));
`default_nettype wire

// ### acc_pin_partner.sv
// external logic at the pins: drives the trigger pin, watches the status pin
// assumes it runs on the bank clock; lag sets how late the pin follows want
`timescale 1ns/1ps
`default_nettype none
module acc_pin_partner (
  input wire logic clk,
  input wire logic want,
  input wire logic [2:0] lag,
  input wire logic status,
  output logic pin,
  output logic seen
);
  logic [7:0] hist = 8'hff;
  // pin idles high so an unused trigger stays high
  always @(posedge clk) begin
    hist <= {hist[6:0], want};
    seen <= status;
  end
  assign pin = hist[lag];
endmodule
`default_nettype wire

// ### test_acc_cal_regs.sv
// self-checking bench for the calibration register bank
// assumes acc_cal_regs, acc_pin_partner and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
module test_acc_cal_regs;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, al = 0, want = 1;
  logic [9:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, e, pin, stp, trig, wake, bgen, irq;
  logic [3:0] ev = 0;
  logic [2:0] code = 0, lag = 0, ofs, lin;
  int fails = 0, tests_run = 0, fgm = 0, stm = 0;
  int m[int];
  initial forever #25 clk = ~clk;
  acc_cal_regs dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cal_restart(ev[3]), .fg_finished(ev[2]),
    .bg_halted(ev[1]), .bg_resumed(ev[0]), .alarm_in(al), .cal_stat_code(code),
    .calibration_trigger_pin(pin), .calibration_status_pin(stp),
    .calibration_trigger(trig), .converter_wake(wake), .offset_averaging_level(ofs),
    .linearity_averaging_level(lin), .background_calibration_enable(bgen), .irq(irq));
  acc_pin_partner pp (.clk(clk), .want(want), .lag(lag), .status(stp), .pin(pin),
    .seen());
  // ==========================================
  // tasks
  task final_report;
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, x, g);
    end
  endtask
  // one apb transfer; hold everything until ready is sampled
  task apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (n == 20) begin
      fails++;
      final_report;
    end
  endtask
  task wr(input int i, input int d);
    apb(1, i, d);
    case (i)
      'h68: m[i] = d & 'h77;
      'h6b, 'h70: m[i] = d & 7;
      'h6c: m[i] = d & 1;
      'h72: m[i] = d & 'h1f;
      default: ;
    endcase
  endtask
  task rd(input int i);
    apb(0, i, 0);
    chk("reg", i == 'h6a ? code * 4 + stm * 2 + fgm : m[i], r);
  endtask
  task pulse(input int b);
    @(posedge clk) ev[b] <= 1;
    @(posedge clk) ev <= 0;
    case (b)
      3: {fgm, stm} = 0;
      2: begin fgm = 1; if (!m['h70][0]) stm = 1; end
      1: if (m['h70][0]) stm = 1;
      default: stm = 0;
    endcase
  endtask
  task chk_pins;
    int t;
    t = m['h6b][0] ? want : m['h6c][0];
    repeat (12) @(posedge clk);
    chk("trigger", t, trig);
    chk("wake", (m['h70] == 7) && !t, wake);
  endtask
  // ==========================================
  // scenarios
  initial begin
    void'($urandom(99));
    repeat (6) @(posedge clk);
    rst_n <= 1;
    m['h68] = 'h61; m['h6b] = 0; m['h6c] = 1; m['h70] = 0; m['h72] = 0;
    foreach (m[i]) rd(i);
    rd('h6a);
    chk("ofs", 6, ofs);
    chk("lin", 1, lin);
    apb(0, 'h55, 0);
    chk("slverr", 1, e);
    repeat (4) begin
      wr('h68, $urandom & 'h77);
      rd('h68);
      chk("levels", m['h68], {1'b0, ofs, 1'b0, lin});
    end
    code <= $urandom;
    wr('h6a, 'h1f);
    rd('h6a);
    wr('h72, 1);
    pulse(2);
    rd('h6a);
    chk("irq", 1, irq);
    apb(1, 'h71, 1);
    @(posedge clk);
    chk("irq", 0, irq);
    pulse(3);
    wr('h70, 1);
    pulse(2);
    rd('h6a);
    pulse(1);
    rd('h6a);
    pulse(0);
    rd('h6a);
    pulse(1);
    @(posedge clk) al <= 1;
    for (int s = 0; s < 4; s++) begin
      wr('h6b, s * 2);
      repeat (3) @(posedge clk);
      chk("status_pin", s == 0 ? fgm : s == 1 ? stm : s == 2, pp.seen);
    end
    wr('h6b, 0);
    wr('h6c, 0);
    @(posedge clk) want <= 0;
    chk_pins;
    wr('h6b, 1);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) lag <= $urandom % 4;
      want <= $urandom;
      wr('h6c, k % 2);
      chk_pins;
    end
    wr('h6b, 0);
    wr('h6c, 0);
    wr('h70, 7);
    chk_pins;
    wr('h6c, 1);
    chk_pins;
    final_report;
  end
endmodule
`default_nettype wire
